/* design/sdi_video_receive_datapath.sv */
// Receive datapath: NRZI decode, descramble, word framing, LSB restore,
// TRS clipping, format tracking, delay line and word-clocked output.
// Assumes serial bits arrive as sys_clk-synchronous enables and that
// the source holds a bit while serialReady is low.
`timescale 1ns/1ps
`default_nettype none

module sdi_video_receive_datapath
    import sdi_rx_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        serialBit,
    input  wire logic        serialValid,
    output wire logic        serialReady,
    input  wire logic        pllLocked,
    input  wire logic        lsbRestoreEnable,
    input  wire logic        blankingLsbRestoreEnable,
    input  wire logic        standardDefRestrict,
    input  wire logic        highDefRestrict,
    input  wire logic [4:0]  formatSelect,
    input  wire logic [2:0]  videoFifoDepth,
    input  wire logic        videoReady,
    output var  logic [19:0] parallelVideoOut,
    output var  logic        videoClk,
    output var  logic        eavFlag,
    output var  logic        savFlag,
    output var  logic        newSyncPositionFlag,
    output var  logic        hdActive,
    output var  logic        formatLocked,
    output var  logic [11:0] lineWords,
    output var  logic [4:0]  formatActive
);

    function automatic logic laneIs(input logic [9:0] x, input logic one);
        laneIs = one ? (&x[9:2]) : ~(|x[9:2]);
    endfunction : laneIs

    function automatic logic wordIs(input logic [19:0] x, input logic one);
        wordIs = laneIs(x[19:10], one) & laneIs(x[9:0], one);
    endfunction : wordIs

    function automatic logic [9:0] clipLane(input logic [9:0] x);
        clipLane = laneIs(x, 1'b1) ? LANE_ONES :
                   laneIs(x, 1'b0) ? LANE_ZEROS : x;
    endfunction : clipLane

    function automatic video_word_t clipWord(input video_word_t w);
        video_word_t r;
        r      = w;
        r.data = {clipLane(w.data[19:10]), clipLane(w.data[9:0])};
        clipWord = r;
    endfunction : clipWord

    video_cfg_t            cfg;
    logic                  prevLine;
    logic [8:0]            scrHist;
    logic [HIST_BITS-1:0]  hist;
    logic [4:0]            bitCnt;
    logic                  hdMode;
    logic                  vBlank;
    logic                  xyzNext;
    logic [LINE_BITS-1:0]  lineCount;
    video_word_t           w0;
    video_word_t           w1;
    video_word_t           w2;
    video_word_t           stage [FIFO_STAGES];
    video_word_t           bufOut;
    logic                  bufValid;

    // Serial front end
    wire bitTaken = serialValid & serialReady;
    wire nrzBit   = serialBit ^ prevLine;
    wire plainBit = nrzBit ^ scrHist[TAP_A] ^ scrHist[TAP_B];
    wire [HIST_BITS-1:0] histNext = {plainBit, hist[HIST_BITS-1:1]};

    // Preamble search at bit level, LSBs ignored as clipping allows
    wire sdPre = laneIs(histNext[59:50], 1'b0)
               & laneIs(histNext[49:40], 1'b0)
               & laneIs(histNext[39:30], 1'b1);
    wire hdPre = ~(|{histNext[59:52], histNext[49:42],
                     histNext[39:32], histNext[29:22]})
               & laneIs(histNext[19:10], 1'b1)
               & laneIs(histNext[9:0], 1'b1);

    wire fmtForced = (cfg.formatSel != 5'h00);
    wire forcedHd  = cfg.formatSel[FMT_HD_BIT];
    // Both restricts set is read as no restriction at all
    wire allowSd   = !(cfg.hdOnly && !cfg.sdOnly)
                   && !(fmtForced && forcedHd);
    wire allowHd   = !(cfg.sdOnly && !cfg.hdOnly)
                   && !(fmtForced && !forcedHd);
    wire hitHd     = bitTaken & pllLocked & allowHd & hdPre;
    wire hitSd     = bitTaken & pllLocked & allowSd & sdPre & !hitHd;
    wire hit       = hitHd | hitSd;
    wire hdSel     = hitHd ? 1'b1 : (hitSd ? 1'b0 : hdMode);
    wire [4:0] lastIdx = hdMode ? HD_LAST : SD_LAST;
    wire atLast    = (bitCnt == lastIdx);
    wire wordStrobe = bitTaken & (hit | atLast);

    // Word assembly: HD keeps chroma low, SD duplicates the lane
    wire [19:0] rawData = hdSel ? histNext[59:40]
                        : {2{histNext[59:50]}};
    wire restoreOn = cfg.lsbRestore
                   & (!vBlank | cfg.blankRestore);
    wire [19:0] restData = restoreOn ? (rawData & RESTORE_MASK) : rawData;
    video_word_t newWord;
    assign newWord.data = restData;
    assign newWord.eav  = xyzNext & restData[XYZ_H_BIT];
    assign newWord.sav  = xyzNext & !restData[XYZ_H_BIT];
    assign newWord.new_sync_position_flag  = hit & !atLast;

    // Word-level TRS check after LSB restore
    wire wordPre = wordIs(w1.data, 1'b1) & wordIs(w0.data, 1'b0)
                 & wordIs(newWord.data, 1'b0);
    // A shifted preamble is rebuilt from history; old words were misframed
    video_word_t preFirst;
    video_word_t preMid;
    assign preFirst = hit ? video_word_t'{hdSel ? histNext[19:0]
                        : {2{histNext[39:30]}}, 1'b0, 1'b0, 1'b0} : w1;
    assign preMid   = hit ? video_word_t'{hdSel ? histNext[39:20]
                        : {2{histNext[49:40]}}, 1'b0, 1'b0, 1'b0} : w0;

    // Delay tap; undefined depth codes saturate
    wire [2:0] depthEff = (cfg.depth > MAX_DEPTH) ? MAX_DEPTH
                        : cfg.depth;
    wire [1:0] tapIdx = 2'(depthEff - 3'h1);
    wire video_word_t tapWord = (depthEff == 3'h0) ? w2
                              : stage[tapIdx];
    wire popWord = bufValid & videoClk & videoReady;

    // Configuration capture: restore enables start cleared
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            cfg <= '0;
        end else begin
            cfg <= '{lsbRestoreEnable, blankingLsbRestoreEnable,
                     standardDefRestrict, highDefRestrict,
                     formatSelect, videoFifoDepth};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prevLine <= 1'b0;
            scrHist  <= '0;
            hist     <= '0;
        end else if (bitTaken) begin
            prevLine <= serialBit;
            scrHist  <= {scrHist[7:0], nrzBit};
            hist     <= histNext;
        end
    end

    // Framing counter restarts at each preamble
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            bitCnt <= '0;
            hdMode <= 1'b0;
        end else if (bitTaken) begin
            if (hit) begin
                bitCnt <= '0;
                hdMode <= hitHd;
            end else begin
                bitCnt <= atLast ? 5'h00 : bitCnt + 5'h01;
            end
        end
    end

    // Word pipeline; a full preamble is clipped in place
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            w0      <= '0;
            w1      <= '0;
            w2      <= '0;
            xyzNext <= 1'b0;
            vBlank  <= 1'b0;
        end else if (wordStrobe) begin
            if (hit | wordPre) begin
                w0 <= clipWord(newWord);
                w1 <= clipWord(preMid);
                w2 <= clipWord(preFirst);
            end else begin
                w0 <= newWord;
                w1 <= w0;
                w2 <= w1;
            end
            xyzNext <= hit | wordPre;
            if (xyzNext) begin
                vBlank <= restData[XYZ_V_BIT];
            end
        end
    end

    generate
        for (genvar i = 0; i < FIFO_STAGES; i++) begin : g_delay
            always_ff @(posedge sys_clk) begin
                if (!reset_n) begin
                    stage[i] <= '0;
                end else if (wordStrobe) begin
                    stage[i] <= (i == 0) ? w2 : stage[(i == 0) ? 0 : i - 1];
                end
            end
        end
    endgenerate

    // Flags follow the word entering the delay input, ahead of output
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            eavFlag             <= 1'b0;
            savFlag             <= 1'b0;
            newSyncPositionFlag <= 1'b0;
        end else if (wordStrobe) begin
            eavFlag             <= w2.eav;
            savFlag             <= w2.sav;
            newSyncPositionFlag <= w2.new_sync_position_flag;
        end
    end

    // Line length measured EAV to EAV; lock needs two equal lines
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            lineCount    <= '0;
            lineWords    <= '0;
            formatLocked <= 1'b0;
            hdActive     <= 1'b0;
            formatActive <= '0;
        end else begin
            hdActive     <= hdMode;
            formatActive <= fmtForced ? cfg.formatSel
                          : {hdMode, 4'h0};
            if (!pllLocked) begin
                formatLocked <= 1'b0;
                lineCount    <= '0;
            end else if (wordStrobe) begin
                if (newWord.eav) begin
                    lineWords    <= lineCount;
                    formatLocked <= (lineCount == lineWords);
                    lineCount    <= 12'h001;
                end else begin
                    lineCount <= lineCount + 12'h001;
                end
            end
        end
    end

    sdi_word_buffer #(
        .WIDTH (BUF_WIDTH),
        .DEPTH (BUF_DEPTH)
    ) u_buffer (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .inValid  (wordStrobe),
        .inData   (tapWord),
        .inReady  (serialReady),
        .outValid (bufValid),
        .outData  (bufOut),
        .outReady (popWord)
    );

    // Word clock falls with each new word and rises a cycle later;
    // a stalled receiver simply sees the clock parked high
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            parallelVideoOut <= '0;
            videoClk         <= 1'b1;
        end else if (popWord) begin
            parallelVideoOut <= bufOut.data;
            videoClk         <= 1'b0;
        end else begin
            videoClk <= 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    AST_DESCRAMBLE: assert property (bitTaken |=> hist[59] ==
        ($past(serialBit) ^ $past(prevLine) ^ $past(scrHist[TAP_A])
         ^ $past(scrHist[TAP_B])))
        else $error("descrambled bit wrong");
    AST_SD_DUP: assert property (wordStrobe && !hdSel |->
        rawData[19:10] == rawData[9:0])
        else $error("SD lanes differ");
    AST_RESTORE_OFF: assert property (
        wordStrobe && !cfg.lsbRestore && !wordPre && !hit |=>
        w0.data == $past(rawData))
        else $error("word altered with restore off");
    AST_RESET_CFG: assert property ($rose(reset_n) |->
        !cfg.lsbRestore && !cfg.blankRestore)
        else $error("restore enables not cleared");
    AST_CLIP: assert property (wordStrobe && (hit || wordPre) |=>
        w2.data == CLIP_ONES && w1.data == 20'h00000
        && w0.data == 20'h00000)
        else $error("TRS not clipped");
    AST_NO_LOCK: assert property (!pllLocked |-> !hit)
        else $error("format change without lock");
    AST_RESTRICT: assert property (
        cfg.sdOnly && !cfg.hdOnly && !fmtForced |-> !hitHd)
        else $error("HD taken while SD restricted");
    AST_DEPTH_CLAMP: assert property (cfg.depth > MAX_DEPTH |->
        depthEff == MAX_DEPTH)
        else $error("depth not clamped");
    AST_FLAGS_ENTRY: assert property (wordStrobe |=>
        eavFlag == $past(w2.eav) && newSyncPositionFlag == $past(w2.new_sync_position_flag))
        else $error("flag not taken at delay input");
    AST_OUT_AT_FALL: assert property (
        !$stable(parallelVideoOut) |-> $fell(videoClk))
        else $error("output moved without clock fall");
    AST_CLK_RISES: assert property (!videoClk |=> videoClk)
        else $error("word clock low for two cycles");

endmodule : sdi_video_receive_datapath

`default_nettype wire

/* design/sdi_rx_pkg.sv */
// Constants and carrier types for the serial video receive datapath.
// Assumes one system clock and configuration held on plain ports.
package sdi_rx_pkg;

    localparam int          HIST_BITS    = 60;
    localparam int          TAP_A        = 3;
    localparam int          TAP_B        = 8;
    localparam logic [4:0]  SD_LAST      = 5'h09;
    localparam logic [4:0]  HD_LAST      = 5'h13;
    localparam logic [19:0] RESTORE_MASK = 20'hFFBFE;
    localparam logic [19:0] CLIP_ONES    = 20'hFFFFF;
    localparam logic [9:0]  LANE_ONES    = 10'h3FF;
    localparam logic [9:0]  LANE_ZEROS   = 10'h000;
    localparam int          XYZ_V_BIT    = 7;
    localparam int          XYZ_H_BIT    = 6;
    localparam int          FMT_HD_BIT   = 4;
    localparam int          FIFO_STAGES  = 4;
    localparam logic [2:0]  MAX_DEPTH    = 3'h4;
    localparam int          LINE_BITS    = 12;
    localparam int          BUF_WIDTH    = 23;
    localparam int          BUF_DEPTH    = 2;

    typedef struct packed {
        logic [19:0] data;
        logic        eav;
        logic        sav;
        logic        new_sync_position_flag;
    } video_word_t;

    typedef struct packed {
        logic       lsbRestore;
        logic       blankRestore;
        logic       sdOnly;
        logic       hdOnly;
        logic [4:0] formatSel;
        logic [2:0] depth;
    } video_cfg_t;

endpackage : sdi_rx_pkg

/* design/sdi_word_buffer.sv */
// Two-entry word buffer with valid/ready on both sides.
// Assumes sys_clk and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module sdi_word_buffer
    import sdi_rx_pkg::*;
#(
    parameter int WIDTH = BUF_WIDTH,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output var  logic             inReady,
    output wire logic             outValid,
    output wire logic [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr;
    logic [PW-1:0]    rdPtr;
    logic [CW-1:0]    count;
    logic [CW-1:0]    countNext;
    wire              pushOk = inValid & inReady;
    wire              popOk  = outValid & outReady;

    assign outValid  = (count != '0);
    assign outData   = mem[rdPtr];
    assign countNext = (pushOk && !popOk) ? count + 1'b1 :
                       (!pushOk && popOk) ? count - 1'b1 : count;

    // Ready is a flop so the source sees an honest, glitch-free stall
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            wrPtr   <= '0;
            rdPtr   <= '0;
            count   <= '0;
            inReady <= 1'b0;
        end else begin
            if (pushOk) begin
                wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
            end
            if (popOk) begin
                rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
            end
            count   <= countNext;
            inReady <= (countNext != CW'(DEPTH));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (pushOk) begin
            mem[wrPtr] <= inData;
        end
    end

endmodule : sdi_word_buffer

`default_nettype wire

/* bench/sdi_serial_source.sv */
// Serial video source model: scrambles, NRZI-codes, sends LSB first.
// Assumes the bench calls its tasks just after a rising sys_clk edge.
`timescale 1ns/1ps
`default_nettype none

module sdi_serial_source (
    input  wire logic sys_clk,
    input  wire logic serialReady,
    output var  logic serialBit,
    output var  logic serialValid
);
    logic [8:0] hist = 9'h000;
    logic       line = 1'h0;
    logic       scr;
    logic       rdy;

    initial begin
        serialBit   = 1'h0;
        serialValid = 1'h0;
    end

    // Each bit is held until an edge that saw serialReady high
    task automatic send_word(input logic [19:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            scr = w[i] ^ hist[3] ^ hist[8];
            hist = {hist[7:0], scr};
            line = line ^ scr;
            serialBit = line;
            serialValid = 1'h1;
            do begin
                rdy = serialReady;
                @(posedge sys_clk);
                #1;
            end while (!rdy);
        end
    endtask : send_word

    // Released line shows the inverse, never a stale bit
    task automatic stop();
        serialValid = 1'h0;
        serialBit = ~line;
    endtask : stop
endmodule : sdi_serial_source

`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the receive datapath.
// Assumes the serial source model and a 50 MHz sys_clk.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int          LIMIT   = 30000;
    localparam logic [19:0] SD_ODD  = {10'h2AB, 10'h2AB};
    localparam logic [19:0] SD_EVEN = {10'h2AA, 10'h2AA};
    localparam logic [19:0] HD_W    = {10'h155, 10'h0AB};
    logic        sys_clk = 1'h0;
    logic        reset_n = 1'h0;
    logic        pllLocked = 1'h1;
    logic        lsbRestoreEnable = 1'h0;
    logic        blankingLsbRestoreEnable = 1'h0;
    logic [4:0]  formatSelect = 5'h02;
    logic [2:0]  videoFifoDepth = 3'h0;
    logic        videoReady = 1'h1;
    logic        standardDefRestrict = 1'h0;
    logic        highDefRestrict = 1'h0;
    logic        autoMode = 1'h0;
    logic        serialBit, serialValid, serialReady;
    logic [19:0] parallelVideoOut, prevData, xyzWord;
    logic        videoClk, eavFlag, savFlag, newSyncPositionFlag;
    logic        hdActive, formatLocked, prevClk;
    logic        savSeen, nspSeen, stallSeen;
    logic [11:0] lineWords;
    logic [4:0]  formatActive;
    logic [19:0] outQ[$];
    int          fails = 0;
    int          nCompared = 0;
    int          cyc = 0;
    int          eavCyc, xyzCyc, lead0, lead4, lead7, leadX;

    always #10 sys_clk = ~sys_clk;

    sdi_video_receive_datapath dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .serialBit(serialBit),
        .serialValid(serialValid), .serialReady(serialReady),
        .pllLocked(pllLocked), .lsbRestoreEnable(lsbRestoreEnable),
        .blankingLsbRestoreEnable(blankingLsbRestoreEnable),
        .standardDefRestrict(standardDefRestrict),
        .highDefRestrict(highDefRestrict),
        .formatSelect(formatSelect), .videoFifoDepth(videoFifoDepth),
        .videoReady(videoReady), .parallelVideoOut(parallelVideoOut),
        .videoClk(videoClk), .eavFlag(eavFlag), .savFlag(savFlag),
        .newSyncPositionFlag(newSyncPositionFlag), .hdActive(hdActive),
        .formatLocked(formatLocked), .lineWords(lineWords),
        .formatActive(formatActive));

    sdi_serial_source src (.sys_clk(sys_clk), .serialReady(serialReady),
        .serialBit(serialBit), .serialValid(serialValid));

    task automatic check(input string what, input logic [19:0] seen,
                         input logic [19:0] exp);
        nCompared++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Compared %0d, mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    // Words are taken as videoClk rises; flags sampled once settled
    always @(posedge sys_clk) begin
        #2;
        cyc++;
        if (reset_n === 1'h1) begin
            if (eavFlag === 1'h1 && eavCyc < 0)
                eavCyc = cyc;
            if (savFlag === 1'h1)
                savSeen = 1'h1;
            if (newSyncPositionFlag === 1'h1)
                nspSeen = 1'h1;
            if (videoReady === 1'h0 && serialReady === 1'h0)
                stallSeen = 1'h1;
            if (videoClk === 1'h1 && prevClk === 1'h0) begin
                outQ.push_back(parallelVideoOut);
                if (parallelVideoOut === xyzWord && xyzCyc < 0)
                    xyzCyc = cyc;
            end
            if (videoClk === 1'h1 && parallelVideoOut !== prevData)
                check("held word", parallelVideoOut, prevData);
        end
        prevClk = videoClk;
        prevData = parallelVideoOut;
        if (cyc == LIMIT) begin
            fails++;
            tally_and_finish();
        end
    end

    // Misaligned preamble with dithered LSBs, XYZ, two data words
    task automatic run_test(input string name, input logic hd,
        input logic [2:0] dep, input logic rst, input logic blk,
        input logic pll, input logic [9:0] xyz, input logic [19:0] dat,
        input logic [19:0] expDat, input logic stall, output int lead);
        int          n;
        int          idx;
        logic [19:0] ex [6];
        n = hd ? 20 : 10;
        formatSelect = autoMode ? 5'h00 : (hd ? 5'h11 : 5'h02);
        videoFifoDepth = dep;
        lsbRestoreEnable = rst;
        blankingLsbRestoreEnable = blk;
        pllLocked = pll;
        reset_n = 1'h0;
        repeat (4) @(posedge sys_clk);
        #1;
        reset_n = 1'h1;
        check("format at reset", 20'(formatActive), 20'h00000);
        outQ.delete();
        xyzWord = {xyz, xyz};
        eavCyc = -1;
        xyzCyc = -1;
        savSeen = 1'h0;
        nspSeen = 1'h0;
        stallSeen = 1'h0;
        idx = -1;
        if (stall) begin
            videoReady = 1'h0;
            fork
                begin
                    repeat (150) @(posedge sys_clk);
                    #1;
                    videoReady = 1'h1;
                end
            join_none
        end
        src.send_word(20'h00000, 3);
        for (int i = 0; i < 3; i++)
            src.send_word(20'h80200, n);
        src.send_word(hd ? 20'hFF7FE : 20'h003FD, n);
        src.send_word(hd ? 20'h00801 : 20'h00002, n);
        src.send_word(hd ? 20'h00003 : 20'h00001, n);
        src.send_word(xyzWord, n);
        src.send_word(dat, n);
        src.send_word(dat, n);
        for (int i = 0; i < 10; i++)
            src.send_word(20'h80200, n);
        src.stop();
        for (int k = 0; k < 300 && outQ.size() < 20; k++)
            @(posedge sys_clk);
        #1;
        for (int i = 0; i < outQ.size() && idx < 0; i++)
            if (outQ[i] === 20'hFFFFF)
                idx = i;
        ex = '{20'hFFFFF, 20'h00000, 20'h00000, xyzWord, expDat, expDat};
        check("nsp seen", 20'(nspSeen), 20'(pll));
        check("eav seen", 20'(eavCyc >= 0), 20'(pll & xyz[6]));
        check("sav seen", 20'(savSeen), 20'(pll & ~xyz[6]));
        check("line words", 20'(lineWords), (pll & xyz[6]) ?
              20'((3 + 6 * n) / 10 + 1) : 20'h00000);
        check("fmt lock", 20'(formatLocked), 20'h00000);
        if (pll) begin
            check("sync found", 20'(idx >= 0), 20'h00001);
            for (int i = 0; i < 6; i++) begin
                if (hd)
                    check("hd word", outQ[idx + i], ex[i]);
                else
                    check("sd word", outQ[idx + i], ex[i]);
            end
            check("format", 20'(formatActive),
                  20'(autoMode ? {hd, 4'h0} : formatSelect));
            check("hd mode", 20'(hdActive), 20'(hd));
        end
        if (stall)
            check("intake stalled", 20'(stallSeen), 20'h00001);
        lead = xyzCyc - eavCyc;
        $display("Test %s done, mismatches so far %0d", name, fails);
    endtask : run_test

    initial begin
        run_test("sd_plain", 1'h0, 3'h0, 1'h0, 1'h0, 1'h1, 10'h274,
                 SD_ODD, SD_ODD, 1'h0, lead0);
        run_test("sd_restore", 1'h0, 3'h0, 1'h1, 1'h0, 1'h1, 10'h274,
                 SD_ODD, SD_EVEN, 1'h0, leadX);
        run_test("blank_off", 1'h0, 3'h0, 1'h1, 1'h0, 1'h1, 10'h2AC,
                 SD_ODD, SD_ODD, 1'h0, leadX);
        run_test("blank_on", 1'h0, 3'h0, 1'h1, 1'h1, 1'h1, 10'h2AC,
                 SD_ODD, SD_EVEN, 1'h0, leadX);
        run_test("depth4", 1'h0, 3'h4, 1'h0, 1'h0, 1'h1, 10'h274,
                 SD_ODD, SD_ODD, 1'h0, lead4);
        check("depth 4 lead", 20'(lead4 - lead0), 20'h00028);
        run_test("depth7", 1'h0, 3'h7, 1'h0, 1'h0, 1'h1, 10'h274,
                 SD_ODD, SD_ODD, 1'h0, lead7);
        check("depth 7 lead", 20'(lead7 - lead0), 20'h00028);
        run_test("hd", 1'h1, 3'h0, 1'h0, 1'h0, 1'h1, 10'h274,
                 HD_W, HD_W, 1'h0, leadX);
        run_test("no_lock", 1'h0, 3'h0, 1'h0, 1'h0, 1'h0, 10'h274,
                 SD_ODD, SD_ODD, 1'h0, leadX);
        run_test("stall", 1'h0, 3'h2, 1'h0, 1'h0, 1'h1, 10'h274,
                 SD_ODD, SD_ODD, 1'h1, leadX);
        autoMode = 1'h1;
        run_test("sd_auto", 1'h0, 3'h0, 1'h0, 1'h0, 1'h1, 10'h274,
                 SD_ODD, SD_ODD, 1'h0, leadX);
        standardDefRestrict = 1'h1;
        run_test("standard_def_restrict", 1'h0, 3'h0, 1'h0, 1'h0, 1'h1, 10'h274,
                 SD_ODD, SD_ODD, 1'h0, leadX);
        standardDefRestrict = 1'h0;
        highDefRestrict = 1'h1;
        run_test("high_def_restrict", 1'h1, 3'h0, 1'h0, 1'h0, 1'h1, 10'h274,
                 HD_W, HD_W, 1'h0, leadX);
        tally_and_finish();
    end
endmodule : testbench

`default_nettype wire
